// >>> src/sed_pkg.sv
/*
 Constants, field layouts and carrier types for the error-code
 generator, checker and error logger.
 Assumes one 200 MHz clock and a 32-bit data word with 7 check bits.
*/
// Operation
// - Ten units: four write-path generators, six read-path checkers.
// - Logged error keeps syndrome, both flags, bus code, address bits 37-58.
// - Each checker forms a 7-bit syndrome from data and check bits.
// - 39 odd codes are single failures; only 32 data codes get corrected.
// - Even nonzero syndrome is double; odd unknown codes judged multi-bit outside.
// - Single flag sets on a single error unless a double came first.
// - Double flag sets on every double error, always.
// - Bus code: 0 I/O, 1-3 vector reads, 4 scalar, 5 fetch.
// - One error logged per cycle: fetch, scalar, vread2, vread1, I/O, vread3.
// - Address fields: chip, word, capacity selects, bank, quarter-sword, half.
// - Check bits give one-hot 40..01; data positions use a fixed table.
// - Simultaneous errors latch by priority; reader checks syndrome on double.
// - First mode latches the first error after a clear and holds it.
// - Second mode lets the first double error overwrite a latched single.
// - Once a double is latched in second mode, it holds until cleared.
// - Double soon after single is logged whole from the double, address included.
// - Double well after single is logged fully correct.
// - Fault force makes every read bus report an error-code fault.
// - Read strobes and request addresses are kept for logging.
`default_nettype none

package sed_pkg;
    localparam int SED_DW = 32;
    localparam int SED_CW = 7;
    localparam int SED_NGEN = 4;
    localparam int SED_NCHK = 6;
    localparam int SED_CLK_NS = 5;
    localparam int SED_MINOR_NS = 20;
    localparam int SED_MIX_MINOR = 8;
    localparam int SED_MIX_CYC = (SED_MIX_MINOR * SED_MINOR_NS + SED_CLK_NS - 1) / SED_CLK_NS;

    // Read bus codes
    localparam logic [2:0] SED_BUS_IO = 3'h0;
    localparam logic [2:0] SED_BUS_V1 = 3'h1;
    localparam logic [2:0] SED_BUS_V2 = 3'h2;
    localparam logic [2:0] SED_BUS_V3 = 3'h3;
    localparam logic [2:0] SED_BUS_SC = 3'h4;
    localparam logic [2:0] SED_BUS_FETCH = 3'h5;

    // Highest priority first
    localparam logic [2:0] SED_PRIO [6] = '{SED_BUS_FETCH, SED_BUS_SC, SED_BUS_V2,
                                            SED_BUS_V1, SED_BUS_IO, SED_BUS_V3};

    // Syndrome of each data position 7..38; entry k is data bit 31-k
    localparam logic [6:0] SED_DCODE [32] = '{
        7'h70, 7'h68, 7'h58, 7'h64, 7'h54, 7'h7C, 7'h7A, 7'h76,
        7'h1C, 7'h1A, 7'h16, 7'h19, 7'h15, 7'h1F, 7'h5E, 7'h5D,
        7'h07, 7'h46, 7'h45, 7'h26, 7'h25, 7'h67, 7'h57, 7'h37,
        7'h61, 7'h51, 7'h31, 7'h49, 7'h29, 7'h79, 7'h75, 7'h6D};

    // Toggles check bit 0, giving syndrome 40
    localparam logic [6:0] SED_FAULT_MASK = 7'h01;

    // Word address, CPU bit 37 in the top field down to bit 58 at the bottom
    typedef struct packed {
        logic [2:0] chip;
        logic [9:0] word;
        logic cap1024;
        logic cap512;
        logic [2:0] bank;
        logic [1:0] qsword;
        logic [1:0] half;
    } sed_addr_t;

    typedef struct packed {
        logic [6:0] syndrome;
        logic [2:0] bus_code;
        sed_addr_t addr;
    } sed_log_t;
endpackage : sed_pkg

`default_nettype wire

// >>> src/sed_gen.sv
/*
 Check bit generator for one write path.
 Assumes data arrives and leaves on the same clock; purely combinational.
*/
`default_nettype none

module sed_gen (
    input wire logic [31:0] data,
    output logic [6:0] check
);
    // Check bit 6-j is parity of data bits whose code holds bit j
    always_comb begin
        check = '0;
        for (int k = 0; k < 32; k++) begin
            for (int j = 0; j < 7; j++) begin
                if (sed_pkg::SED_DCODE[k][j]) begin
                    check[6 - j] = check[6 - j] ^ data[31 - k];
                end
            end
        end
    end
endmodule : sed_gen

`default_nettype wire

// >>> src/sed_chk.sv
/*
 Syndrome checker and corrector for one read path.
 Assumes registered inputs; purely combinational.
*/
`default_nettype none

module sed_chk (
    input wire logic [31:0] data,
    input wire logic [6:0] check,
    input wire logic correct_en,
    output logic [6:0] syndrome,
    output logic is_double,
    output logic [31:0] data_fixed
);
    logic [6:0] expect_chk;

    always_comb begin
        expect_chk = '0;
        for (int k = 0; k < 32; k++) begin
            for (int j = 0; j < 7; j++) begin
                if (sed_pkg::SED_DCODE[k][j]) begin
                    expect_chk[6 - j] = expect_chk[6 - j] ^ data[31 - k];
                end
            end
        end
        for (int j = 0; j < 7; j++) begin
            syndrome[j] = expect_chk[6 - j] ^ check[6 - j];
        end
        is_double = (syndrome != 7'h00) && !(^syndrome);
        data_fixed = data;
        // Check-bit and unknown odd codes leave the data untouched
        if (correct_en && (^syndrome)) begin
            for (int k = 0; k < 32; k++) begin
                if (syndrome == sed_pkg::SED_DCODE[k]) begin
                    data_fixed[31 - k] = ~data[31 - k];
                end
            end
        end
    end
endmodule : sed_chk

`default_nettype wire

// >>> src/sed_error_logger.sv
/*
 Error-code units for the memory paths and the error log latch.
 Assumes clears, strobes, data and addresses come from logic on clk;
 only the mode select line comes from the maintenance side and is
 synchronised here.
*/
`default_nettype none

module sed_error_logger (
    input wire logic clk,
    input wire logic resetn,
    input wire logic master_clear,
    input wire logic error_clear,
    input wire logic log_mode_two_pin,
    input wire logic correct_en,
    input wire logic fault_force,
    input wire logic [3:0][31:0] wr_data,
    output logic [3:0][6:0] wr_check,
    input wire logic [5:0] rd_strobe,
    input wire logic [5:0][31:0] rd_data,
    input wire logic [5:0][6:0] rd_check,
    input wire sed_pkg::sed_addr_t [5:0] rd_addr,
    output logic [5:0][31:0] rd_data_out,
    output logic [5:0] rd_valid_out,
    output sed_pkg::sed_log_t log_info,
    output logic log_valid,
    output logic single_flag,
    output logic double_flag
);
    // ----------------------------------------------------------------
    // Mode select synchroniser
    // ----------------------------------------------------------------
    // A mode change lands two edges late; switch modes only while the log is idle
    logic mode_meta;
    logic mode_two;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_meta <= 1'b0;
            mode_two <= 1'b0;
        end else begin
            mode_meta <= log_mode_two_pin;
            mode_two <= mode_meta;
        end
    end

    // ----------------------------------------------------------------
    // Write path generators
    // ----------------------------------------------------------------
    logic [3:0][6:0] gen_check;
    logic [3:0][6:0] next_wr_check;

    for (genvar g = 0; g < sed_pkg::SED_NGEN; g++) begin : g_gen
        sed_gen sed_gen_i (
            .data(wr_data[g]),
            .check(gen_check[g])
        );
    end

    // Registered so each check output leaves a flip-flop, at one cycle of latency
    always_comb begin
        next_wr_check = gen_check;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_check <= '0;
        end else begin
            wr_check <= next_wr_check;
        end
    end

    // ----------------------------------------------------------------
    // Read capture stage: strobe, data and request address
    // ----------------------------------------------------------------
    logic [5:0] s1_strobe;
    logic [5:0][31:0] s1_data;
    logic [5:0][6:0] s1_check;
    sed_pkg::sed_addr_t [5:0] s1_addr;
    logic [5:0] next_s1_strobe;
    logic [5:0][31:0] next_s1_data;
    logic [5:0][6:0] next_s1_check;
    sed_pkg::sed_addr_t [5:0] next_s1_addr;

    always_comb begin
        next_s1_strobe = rd_strobe;
        next_s1_data = rd_data;
        next_s1_addr = rd_addr;
        // Fault goes in ahead of the register so the checker sees a real flip
        for (int b = 0; b < sed_pkg::SED_NCHK; b++) begin
            next_s1_check[b] = fault_force ? (rd_check[b] ^ sed_pkg::SED_FAULT_MASK)
                                           : rd_check[b];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_strobe <= '0;
            s1_data <= '0;
            s1_check <= '0;
            s1_addr <= '0;
        end else begin
            s1_strobe <= next_s1_strobe;
            s1_data <= next_s1_data;
            s1_check <= next_s1_check;
            s1_addr <= next_s1_addr;
        end
    end

    // ----------------------------------------------------------------
    // Read path checkers
    // ----------------------------------------------------------------
    logic [5:0][6:0] syn;
    logic [5:0] syn_dbl;
    logic [5:0][31:0] fixed;
    logic [5:0] err_v;
    logic [5:0] dbl_v;
    logic [5:0] sgl_v;

    for (genvar c = 0; c < sed_pkg::SED_NCHK; c++) begin : g_chk
        sed_chk sed_chk_i (
            .data(s1_data[c]),
            .check(s1_check[c]),
            .correct_en(correct_en),
            .syndrome(syn[c]),
            .is_double(syn_dbl[c]),
            .data_fixed(fixed[c])
        );
        assign err_v[c] = s1_strobe[c] && (syn[c] != 7'h00);
        assign dbl_v[c] = s1_strobe[c] && syn_dbl[c];
        assign sgl_v[c] = err_v[c] && !syn_dbl[c];
    end

    logic [5:0][31:0] next_rd_data_out;
    logic [5:0] next_rd_valid_out;

    always_comb begin
        next_rd_data_out = fixed;
        next_rd_valid_out = s1_strobe;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_out <= '0;
            rd_valid_out <= '0;
        end else begin
            rd_data_out <= next_rd_data_out;
            rd_valid_out <= next_rd_valid_out;
        end
    end

    // ----------------------------------------------------------------
    // Error log latch
    // ----------------------------------------------------------------
    // Highest-priority bus among those flagged in the mask
    function automatic logic [2:0] sed_pick(input logic [5:0] m);
        logic [2:0] r;
        r = sed_pkg::SED_PRIO[0];
        for (int i = sed_pkg::SED_NCHK - 1; i >= 0; i--) begin
            if (m[sed_pkg::SED_PRIO[i]]) begin
                r = sed_pkg::SED_PRIO[i];
            end
        end
        return r;
    endfunction : sed_pick

    logic clr;
    logic held_dbl;
    logic base_valid;
    logic base_hdbl;
    logic base_df;
    logic [2:0] pick_any;
    logic [2:0] pick_dbl;
    sed_pkg::sed_log_t next_log_info;
    logic next_log_valid;
    logic next_held_dbl;
    logic next_single_flag;
    logic next_double_flag;

    // Either clear has the same effect; the log does not tell them apart
    assign clr = master_clear || error_clear;
    assign pick_any = sed_pick(err_v);
    assign pick_dbl = sed_pick(dbl_v);

    // A clear in the same cycle as an error re-arms first, so the error is kept
    always_comb begin
        base_valid = clr ? 1'b0 : log_valid;
        base_hdbl = clr ? 1'b0 : held_dbl;
        base_df = clr ? 1'b0 : double_flag;
        next_log_info = log_info;
        next_log_valid = base_valid;
        next_held_dbl = base_hdbl;
        next_double_flag = base_df || (dbl_v != 6'h00);
        next_single_flag = (clr ? 1'b0 : single_flag) || ((sgl_v != 6'h00) && !base_df);
        if (!base_valid && (err_v != 6'h00)) begin
            // May latch a single while a double sets the flag
            next_log_info.syndrome = syn[pick_any];
            next_log_info.bus_code = pick_any;
            next_log_info.addr = s1_addr[pick_any];
            next_log_valid = 1'b1;
            next_held_dbl = syn_dbl[pick_any];
        end else if (mode_two && base_valid && !base_hdbl && (dbl_v != 6'h00)) begin
            // Whole entry from the double error, so address is exact
            // Costs a wide mux, but the log never mixes two requests
            next_log_info.syndrome = syn[pick_dbl];
            next_log_info.bus_code = pick_dbl;
            next_log_info.addr = s1_addr[pick_dbl];
            next_held_dbl = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            log_info <= '0;
            log_valid <= 1'b0;
            held_dbl <= 1'b0;
            single_flag <= 1'b0;
            double_flag <= 1'b0;
        end else begin
            log_info <= next_log_info;
            log_valid <= next_log_valid;
            held_dbl <= next_held_dbl;
            single_flag <= next_single_flag;
            double_flag <= next_double_flag;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Flags, a first-mode log and a latched double stand until a clear; each hold but the single flag's is checked every cycle

    chk_dbl_flag_sets: assert property (
        (dbl_v != 6'h00) |=> double_flag)
        else $error("double flag missed a double error");

    chk_first_err_hold: assert property (
        (!mode_two && log_valid && !clr) |=> $stable(log_info) && log_valid)
        else $error("first-mode log changed without clear");

    chk_dbl_log_hold: assert property (
        (held_dbl && !clr) |=> $stable(log_info) && held_dbl)
        else $error("latched double error overwritten");

    chk_dbl_overwrite: assert property (
        (mode_two && log_valid && !held_dbl && !clr && (dbl_v != 6'h00))
        |=> held_dbl && !(^log_info.syndrome) && (log_info.syndrome != 7'h00))
        else $error("double error failed to overwrite single");

    chk_single_flag_set: assert property (
        ((sgl_v != 6'h00) && !double_flag && !clr) |=> single_flag)
        else $error("single flag missed a single error");

    chk_single_blocked: assert property (
        (double_flag && !clr && !single_flag) |=> !single_flag)
        else $error("single flag set after a double error");

    chk_clear_rearm: assert property (
        (clr && (err_v == 6'h00)) |=> !log_valid && !double_flag && !single_flag)
        else $error("clear did not re-arm the log");

    chk_fetch_prio: assert property (
        ((!log_valid || clr) && err_v[sed_pkg::SED_BUS_FETCH])
        |=> log_info.bus_code == sed_pkg::SED_BUS_FETCH)
        else $error("fetch bus error lost priority");

    chk_fault_force: assert property (
        (fault_force && rd_strobe[0]) |=> err_v[0] ##1 log_valid)
        else $error("forced fault not seen on read bus");

    chk_rd_valid_pipe: assert property (
        rd_valid_out == $past(rd_strobe, 2))
        else $error("read valid out of step with its strobe");

    chk_bus_code_range: assert property (
        log_valid |-> (log_info.bus_code <= sed_pkg::SED_BUS_FETCH))
        else $error("logged bus code out of range");

    chk_dbl_syn_even: assert property (
        held_dbl |-> (log_info.syndrome != 7'h00) && !(^log_info.syndrome))
        else $error("latched double error holds a single syndrome");

    chk_log_addr_kept: assert property (
        ((!log_valid || clr) && err_v[sed_pkg::SED_BUS_FETCH])
        |=> (log_info.addr == $past(s1_addr[sed_pkg::SED_BUS_FETCH])))
        else $error("logged address differs from the request address");

    chk_data_bit_fix: assert property (
        (s1_strobe[sed_pkg::SED_BUS_FETCH] && correct_en
            && (syn[sed_pkg::SED_BUS_FETCH] == sed_pkg::SED_DCODE[sed_pkg::SED_DW - 1]))
        |=> (rd_data_out[sed_pkg::SED_BUS_FETCH][0]
            != $past(s1_data[sed_pkg::SED_BUS_FETCH][0])))
        else $error("single data bit error not corrected");

    chk_check_bit_keep: assert property (
        (s1_strobe[sed_pkg::SED_BUS_FETCH] && ($countones(syn[sed_pkg::SED_BUS_FETCH]) == 1))
        |=> (rd_data_out[sed_pkg::SED_BUS_FETCH] == $past(s1_data[sed_pkg::SED_BUS_FETCH])))
        else $error("check bit error altered the data");

    chk_dbl_flag_hold: assert property (
        (double_flag && !clr) |=> double_flag)
        else $error("double flag dropped without a clear");
endmodule : sed_error_logger

`default_nettype wire

// >>> tb/sed_mem_model.sv
/*
 Far side of the error logger: read buses carrying codewords and the
 maintenance line that selects the second latch mode.
 Assumes the bench sets the word and flip masks and raises the strobe.
*/
`default_nettype none

module sed_mem_model (
    input wire logic [5:0] strobe,
    input wire logic [5:0][31:0] word,
    input wire logic [5:0][31:0] dflip,
    input wire logic [5:0][6:0] cflip,
    input wire logic mode_req,
    output logic [5:0][31:0] rd_data,
    output logic [5:0][6:0] rd_check,
    output logic log_mode_two_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Encoder, check bit i holds code 40>>i
    // ----------------------------------------
    function automatic logic [6:0] enc(input logic [31:0] d);
        logic [6:0] c;
        c = '0;
        for (int k = 0; k < 32; k++) begin
            for (int i = 0; i < 7; i++) begin
                c[i] = c[i] ^ (d[31-k] & sed_pkg::SED_DCODE[k][6-i]);
            end
        end
        return c;
    endfunction : enc

    // Idle buses show the inverse so a stale word never looks valid
    always_comb begin
        for (int b = 0; b < 6; b++) begin
            rd_data[b] = strobe[b] ? word[b] ^ dflip[b] : ~word[b];
            rd_check[b] = strobe[b] ? enc(word[b]) ^ cflip[b] : ~enc(word[b]);
        end
    end

    assign log_mode_two_pin = mode_req;
endmodule : sed_mem_model

`default_nettype wire

// >>> tb/secded_error_logger_tb.sv
/*
 Self-checking bench for the error logger: read sequences with injected
 flips, then log and flag checks.
 Assumes log and read outputs show two edges after the strobe is driven
 with read outputs standing one cycle and the log until a clear or a second-mode double; check bits one edge after write data.
*/
`default_nettype none

module secded_error_logger_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] W = 32'hC3A5_5A3C;
    localparam logic [6:0] D2 = sed_pkg::SED_DCODE[30] ^ sed_pkg::SED_DCODE[31];

    logic clk = 1'b0, resetn = 1'b0, master_clear = 1'b0, error_clear = 1'b0;
    logic correct_en = 1'b0, fault_force = 1'b0, mode_req = 1'b0, log_mode_two_pin;
    logic [3:0][31:0] wr_data = '0;
    logic [3:0][6:0] wr_check;
    logic [5:0] rd_strobe = '0, rd_valid_out;
    logic [5:0][31:0] word = '0, dflip = '0, rd_data, rd_data_out;
    logic [5:0][6:0] cflip = '0, rd_check;
    sed_pkg::sed_addr_t [5:0] rd_addr = '0;
    sed_pkg::sed_log_t log_info;
    logic log_valid, single_flag, double_flag;
    int n_fail = 0, samples_checked = 0, cyc = 0;

    always #2.5 clk = ~clk;

    sed_mem_model sed_mem_model_i (.strobe(rd_strobe), .word(word), .dflip(dflip),
        .cflip(cflip), .mode_req(mode_req), .rd_data(rd_data), .rd_check(rd_check),
        .log_mode_two_pin(log_mode_two_pin));

    sed_error_logger sed_error_logger_i (.clk(clk), .resetn(resetn),
        .master_clear(master_clear), .error_clear(error_clear),
        .log_mode_two_pin(log_mode_two_pin), .correct_en(correct_en),
        .fault_force(fault_force), .wr_data(wr_data), .wr_check(wr_check),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_check(rd_check), .rd_addr(rd_addr),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .log_info(log_info),
        .log_valid(log_valid), .single_flag(single_flag), .double_flag(double_flag));

    // ----------------------------------------
    // Compare, verdict, hang guard
    // ----------------------------------------
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task results;
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            results();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task clr(input logic m);
        @(posedge clk);
        if (m) master_clear <= 1'b1;
        else error_clear <= 1'b1;
        @(posedge clk);
        master_clear <= 1'b0;
        error_clear <= 1'b0;
        @(posedge clk);
        #1;
        chk(log_valid, 0);
        chk({single_flag, double_flag}, 0);
    endtask : clr

    // One strobe on the buses in s, same flips on each, address base plus bus
    task rd(input logic [5:0] s, input logic [31:0] df, input logic [6:0] cf, input int base);
        @(posedge clk);
        for (int b = 0; b < 6; b++) begin
            word[b] <= W ^ 32'(b);
            dflip[b] <= df;
            cflip[b] <= cf;
            rd_addr[b] <= 22'(base + b);
        end
        rd_strobe <= s;
        @(posedge clk);
        rd_strobe <= '0;
        // Read outputs stand only for the cycle after this edge
        @(posedge clk);
        #1;
        chk(rd_valid_out, s);
        for (int b = 0; b < 6; b++) begin
            if (s[b]) chk(rd_data_out[b], (correct_en && !fault_force && cf == 0
                && $countones(df) == 1) ? W ^ 32'(b) : W ^ 32'(b) ^ df);
        end
    endtask : rd

    task lg(input logic sf, input logic dbl, input logic [6:0] sy, input logic [2:0] bus,
            input int base);
        chk(log_valid, 1);
        chk(single_flag, sf);
        chk(double_flag, dbl);
        chk(log_info.syndrome, sy);
        chk(log_info.bus_code, bus);
        chk(log_info.addr, 22'(base + bus));
    endtask : lg

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [5:0] m;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int g = 0; g < 4; g++) wr_data[g] <= W ^ 32'(g * 7);
        @(posedge clk);
        #1;
        for (int g = 0; g < 4; g++) chk(wr_check[g], sed_mem_model_i.enc(W ^ 32'(g * 7)));
        rd(6'h20, 0, 0, 0);
        chk(log_valid, 0);
        for (int i = 0; i < 7; i++) begin
            clr(i[0]);
            rd(6'h20, 0, 7'(1 << i), i);
            lg(1, 0, 7'h40 >> i, 5, i);
        end
        for (int k = 0; k < 32; k++) begin
            @(posedge clk) correct_en <= k[0];
            clr(0);
            rd(6'h10, 32'h1 << (31 - k), 0, k);
            lg(1, 0, sed_pkg::SED_DCODE[k], 4, k);
        end
        for (int p = 0; p < 6; p++) begin
            m = '0;
            for (int q = p; q < 6; q++) m[sed_pkg::SED_PRIO[q]] = 1'b1;
            clr(0);
            rd(m, 32'h1, 0, 8 * p);
            lg(1, 0, 7'h6D, sed_pkg::SED_PRIO[p], 8 * p);
        end
        // First mode keeps the first error even against a double
        clr(1);
        rd(6'h01, 32'h1, 0, 100);
        rd(6'h20, 32'h3, 0, 200);
        lg(1, 1, 7'h6D, 0, 100);
        clr(0);
        rd(6'h08, 32'h3, 0, 300);
        rd(6'h20, 32'h1, 0, 400);
        lg(0, 1, D2, 3, 300);
        // Second mode, double well after single
        @(posedge clk) mode_req <= 1'b1;
        repeat (3) @(posedge clk);
        clr(0);
        rd(6'h02, 32'h1, 0, 500);
        repeat (sed_pkg::SED_MIX_CYC) @(posedge clk);
        rd(6'h04, 32'h3, 0, 600);
        lg(1, 1, D2, 2, 600);
        rd(6'h10, 32'h3, 0, 700);
        rd(6'h20, 32'h1, 0, 800);
        lg(1, 1, D2, 2, 600);
        // Double soon after single: the whole entry is the double's; only the half address field is checked
        clr(0);
        rd(6'h02, 32'h1, 0, 1300);
        rd(6'h04, 32'h3, 0, 1400);
        chk({single_flag, double_flag, log_info.syndrome, log_info.bus_code}, {2'h3, D2, 3'h2});
        chk(log_info.addr.half, 2'h2);
        // Second mode: a latched check bit single holds against a later single, then a double overwrites it
        clr(0);
        rd(6'h01, 0, 7'h08, 900);
        rd(6'h20, 32'h1, 0, 1000);
        lg(1, 0, 7'h08, 0, 900);
        rd(6'h20, 32'h3, 0, 1100);
        lg(1, 1, D2, 5, 1100);
        @(posedge clk) begin
            mode_req <= 1'b0;
            fault_force <= 1'b1;
        end
        repeat (3) @(posedge clk);
        clr(0);
        rd(6'h3F, 0, 0, 1200);
        lg(1, 0, 7'h40, 5, 1200);
        results();
    end
endmodule : secded_error_logger_tb

`default_nettype wire
